// [fcr_pkg.sv]
package fcr_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0] REG_STATUS_CTRL = 4'h0;
    localparam logic [3:0] REG_MODE_CTRL = 4'h1;
    localparam int BIT_READY = 0;
    localparam int BIT_REWRITE_EN = 1;
    localparam int BIT_UNLOCK = 2;
    localparam int BIT_STOP = 3;
    localparam int BIT_PROG_ERR = 6;
    localparam int BIT_ERASE_ERR = 7;
    localparam int BIT_MODE_SEL = 1;
    localparam int SR_READY = 7;
    localparam int SR_ERASE = 5;
    localparam int SR_PROGRAM = 4;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;

    typedef enum logic {
        FCR_OP_PROGRAM,
        FCR_OP_ERASE
    } fcr_op_kind_e;

    typedef enum {
        FCR_ST_ARRAY,
        FCR_ST_STATUS,
        FCR_ST_PROG_ARG,
        FCR_ST_ERASE_ARG,
        FCR_ST_BUSY
    } fcr_state_e;

    typedef struct packed {
        fcr_op_kind_e kind;
        logic [19:0] addr;
        logic [15:0] data;
    } fcr_op_s;
endpackage

// [fcr_flash_cpu_rewrite_control.sv]
`timescale 1ns/1ps
// How it works
// - Rewrite enable at 1 accepts commands; mode select 0 means RAM-executed mode.
// - Protected bits reach 1 only by writing 0 then 1; software avoids interruptions.
// - Mode select set by 0-then-1 gives flash-executed mode, only with rewrite enabled.
// - Flash-executed mode never shows the status register; only control flags report.
// - Flash-executed mode holds the CPU from operation start until completion.
// - Ready flag is 0 during an automatic operation, 1 otherwise.
// - Low block unlock at 0 ignores program and erase to blocks 0 and 1.
// - Flash stop blocks access, initialises control and lowers current.
// - Flash stop acts only while rewrite enabled; otherwise it is only stored.
// - Read-only program error flag is 1 after a failed program.
// - Read-only erase error flag is 1 after a failed erase.
// - Error flags clear only by the clear-status command or a non-maskable or watchdog interrupt.
// - Writing 0 to rewrite enable clears rewrite enable and mode select.
// - After an operation: status-read mode in RAM mode, array-read in flash mode.
// - While the CPU is held, I/O ports keep their previous state.
// - Non-maskable or watchdog interrupt resets both registers and aborts rewrite.
// - Program is code 40h then data to the same even address.
// - Erase is code 20h then D0h to the block's uppermost even address.
module fcr_flash_cpu_rewrite_control #(
    parameter int ADDR_W = 20,
    parameter logic [19:0] LOW_BLOCK_LO = 20'hF0000,
    parameter logic [19:0] LOW_BLOCK_HI = 20'hFFFFF
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic cmd_wr,
    input wire logic [19:0] cmd_addr,
    input wire logic [15:0] cmd_data,
    input wire logic op_done,
    input wire logic op_fail,
    input wire logic nmi_or_wdt,
    output logic op_start,
    output fcr_pkg::fcr_op_s op_req,
    output logic op_abort,
    output logic status_read_sel,
    output logic [7:0] status_byte,
    output logic cpu_hold,
    output logic port_freeze,
    output logic flash_stop_active
);
    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    if (ADDR_W != 20) begin : g_bad_width
        $error("ADDR_W must be 20");
    end
    if (LOW_BLOCK_LO > LOW_BLOCK_HI) begin : g_bad_range
        $error("Low block range reversed");
    end

    function automatic logic is_low_block(input logic [19:0] a);
        is_low_block = (a >= LOW_BLOCK_LO) && (a <= LOW_BLOCK_HI);
    endfunction

    logic rewrite_en_r, unlock_r, stop_r, mode_r;
    logic prog_err_r, erase_err_r;
    logic arm_en_r, arm_unlock_r, arm_mode_r;
    logic [7:0] rdata_r, status_r;
    logic start_r;
    fcr_pkg::fcr_op_s req_r;
    fcr_pkg::fcr_state_e state_r;
    logic [19:0] first_addr_r;
    logic wr0, wr1, busy, cmd_ok, cmd_even, clear_cmd, second_hit, protect_hit;

    assign wr0 = reg_wr && (reg_addr == fcr_pkg::REG_STATUS_CTRL);
    assign wr1 = reg_wr && (reg_addr == fcr_pkg::REG_MODE_CTRL);
    assign busy = (state_r == fcr_pkg::FCR_ST_BUSY);
    assign flash_stop_active = stop_r && rewrite_en_r;
    assign cmd_even = cmd_wr && !cmd_addr[0];
    assign cmd_ok = cmd_even && rewrite_en_r && !flash_stop_active && !busy;
    assign clear_cmd = cmd_ok && (state_r == fcr_pkg::FCR_ST_ARRAY
        || state_r == fcr_pkg::FCR_ST_STATUS)
        && cmd_data[7:0] == fcr_pkg::CMD_CLEAR_STATUS;
    assign second_hit = cmd_ok && ((state_r == fcr_pkg::FCR_ST_PROG_ARG
        && cmd_addr == first_addr_r)
        || (state_r == fcr_pkg::FCR_ST_ERASE_ARG
        && cmd_data[7:0] == fcr_pkg::CMD_CONFIRM));
    assign protect_hit = !unlock_r && is_low_block(cmd_addr);

    // ****************************************************************
    // Protected bit sequencing
    // ****************************************************************
    // Arming survives reads; any other write breaks the 0-then-1 pair
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            arm_en_r <= 1'b0;
            arm_unlock_r <= 1'b0;
            arm_mode_r <= 1'b0;
        end else if (nmi_or_wdt) begin
            arm_en_r <= 1'b0;
            arm_unlock_r <= 1'b0;
            arm_mode_r <= 1'b0;
        end else if (reg_wr) begin
            arm_en_r <= wr0 && !reg_wdata[fcr_pkg::BIT_REWRITE_EN];
            arm_unlock_r <= wr0 && !reg_wdata[fcr_pkg::BIT_UNLOCK];
            arm_mode_r <= wr1 && !reg_wdata[fcr_pkg::BIT_MODE_SEL];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rewrite_en_r <= 1'b0;
            unlock_r <= 1'b0;
            stop_r <= 1'b0;
            mode_r <= 1'b0;
        end else if (nmi_or_wdt) begin
            rewrite_en_r <= 1'b0;
            unlock_r <= 1'b0;
            stop_r <= 1'b0;
            mode_r <= 1'b0;
        end else begin
            if (wr0) begin
                stop_r <= reg_wdata[fcr_pkg::BIT_STOP];
                if (!reg_wdata[fcr_pkg::BIT_REWRITE_EN]) begin
                    rewrite_en_r <= 1'b0;
                    mode_r <= 1'b0;
                end else if (arm_en_r) begin
                    rewrite_en_r <= 1'b1;
                end
                if (!reg_wdata[fcr_pkg::BIT_UNLOCK]) begin
                    unlock_r <= 1'b0;
                end else if (arm_unlock_r) begin
                    unlock_r <= 1'b1;
                end
            end
            if (wr1) begin
                if (!reg_wdata[fcr_pkg::BIT_MODE_SEL]) begin
                    mode_r <= 1'b0;
                end else if (arm_mode_r && rewrite_en_r) begin
                    mode_r <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Command sequencer
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= fcr_pkg::FCR_ST_ARRAY;
            first_addr_r <= 20'h00000;
        end else if (nmi_or_wdt || flash_stop_active) begin
            state_r <= fcr_pkg::FCR_ST_ARRAY;
        end else begin
            unique case (state_r)
                fcr_pkg::FCR_ST_ARRAY, fcr_pkg::FCR_ST_STATUS: begin
                    if (cmd_ok) begin
                        first_addr_r <= cmd_addr;
                        unique case (cmd_data[7:0])
                            fcr_pkg::CMD_READ_ARRAY: state_r <= fcr_pkg::FCR_ST_ARRAY;
                            fcr_pkg::CMD_READ_STATUS: begin
                                if (!mode_r) begin
                                    state_r <= fcr_pkg::FCR_ST_STATUS;
                                end
                            end
                            fcr_pkg::CMD_PROGRAM: state_r <= fcr_pkg::FCR_ST_PROG_ARG;
                            fcr_pkg::CMD_ERASE: state_r <= fcr_pkg::FCR_ST_ERASE_ARG;
                            default: state_r <= state_r;
                        endcase
                    end
                end
                fcr_pkg::FCR_ST_PROG_ARG, fcr_pkg::FCR_ST_ERASE_ARG: begin
                    if (second_hit && !protect_hit) begin
                        state_r <= fcr_pkg::FCR_ST_BUSY;
                    end else if (cmd_ok) begin
                        state_r <= fcr_pkg::FCR_ST_ARRAY;
                    end
                end
                fcr_pkg::FCR_ST_BUSY: begin
                    if (op_done) begin
                        state_r <= mode_r ? fcr_pkg::FCR_ST_ARRAY
                            : fcr_pkg::FCR_ST_STATUS;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            start_r <= 1'b0;
            req_r <= '0;
        end else begin
            start_r <= !nmi_or_wdt && !flash_stop_active && second_hit && !protect_hit;
            if (second_hit) begin
                req_r.kind <= (state_r == fcr_pkg::FCR_ST_ERASE_ARG)
                    ? fcr_pkg::FCR_OP_ERASE : fcr_pkg::FCR_OP_PROGRAM;
                req_r.addr <= cmd_addr;
                req_r.data <= cmd_data;
            end
        end
    end

    // ****************************************************************
    // Error flags
    // ****************************************************************
    // A failure landing with a clear cannot occur: clear is refused while busy
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_err_r <= 1'b0;
            erase_err_r <= 1'b0;
        end else if (nmi_or_wdt) begin
            prog_err_r <= 1'b0;
            erase_err_r <= 1'b0;
        end else if (busy && op_done && op_fail) begin
            prog_err_r <= prog_err_r || (req_r.kind == fcr_pkg::FCR_OP_PROGRAM);
            erase_err_r <= erase_err_r || (req_r.kind == fcr_pkg::FCR_OP_ERASE);
        end else if (clear_cmd) begin
            prog_err_r <= 1'b0;
            erase_err_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Read paths
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= fcr_pkg::BYTE_ZERO;
            status_r <= fcr_pkg::BYTE_ZERO;
        end else begin
            status_r <= fcr_pkg::BYTE_ZERO;
            status_r[fcr_pkg::SR_READY] <= !busy;
            status_r[fcr_pkg::SR_ERASE] <= erase_err_r;
            status_r[fcr_pkg::SR_PROGRAM] <= prog_err_r;
            rdata_r <= fcr_pkg::BYTE_ZERO;
            if (reg_rd && reg_addr == fcr_pkg::REG_STATUS_CTRL) begin
                rdata_r[fcr_pkg::BIT_READY] <= !busy;
                rdata_r[fcr_pkg::BIT_REWRITE_EN] <= rewrite_en_r;
                rdata_r[fcr_pkg::BIT_UNLOCK] <= unlock_r;
                rdata_r[fcr_pkg::BIT_STOP] <= stop_r;
                rdata_r[fcr_pkg::BIT_PROG_ERR] <= prog_err_r;
                rdata_r[fcr_pkg::BIT_ERASE_ERR] <= erase_err_r;
            end else if (reg_rd && reg_addr == fcr_pkg::REG_MODE_CTRL) begin
                rdata_r[fcr_pkg::BIT_MODE_SEL] <= mode_r;
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign status_byte = status_r;
    assign op_start = start_r;
    assign op_req = req_r;
    assign op_abort = busy && (nmi_or_wdt || flash_stop_active);
    assign status_read_sel = !mode_r && (state_r == fcr_pkg::FCR_ST_STATUS
        || state_r == fcr_pkg::FCR_ST_BUSY);
    assign cpu_hold = busy && mode_r;
    assign port_freeze = busy && mode_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_enter;
        wr0 && reg_wdata[fcr_pkg::BIT_REWRITE_EN] && arm_en_r && !nmi_or_wdt |=> rewrite_en_r;
    endproperty
    a_enter: assert property (p_enter) else $error("Rewrite enable not set");
    property p_sequence;
        wr0 && reg_wdata[fcr_pkg::BIT_REWRITE_EN] && !arm_en_r && !rewrite_en_r
            |=> !rewrite_en_r;
    endproperty
    a_sequence: assert property (p_sequence) else $error("Enable set without 0 first");
    property p_mode_needs_en;
        $rose(mode_r) |-> rewrite_en_r && $past(arm_mode_r);
    endproperty
    a_mode_needs_en: assert property (p_mode_needs_en) else $error("Mode set illegally");
    property p_clear_both;
        wr0 && !reg_wdata[fcr_pkg::BIT_REWRITE_EN] |=> !rewrite_en_r && !mode_r;
    endproperty
    a_clear_both: assert property (p_clear_both) else $error("Enable clear kept mode");
    property p_no_status_fm;
        mode_r && cmd_ok && state_r == fcr_pkg::FCR_ST_ARRAY
            && cmd_data[7:0] == fcr_pkg::CMD_READ_STATUS
            |=> state_r != fcr_pkg::FCR_ST_STATUS && !status_read_sel;
    endproperty
    a_no_status_fm: assert property (p_no_status_fm) else $error("Status in flash mode");
    property p_hold;
        start_r && mode_r && !nmi_or_wdt && !flash_stop_active |-> cpu_hold && port_freeze;
    endproperty
    a_hold: assert property (p_hold) else $error("CPU not held");
    property p_ready;
        busy |=> !status_r[fcr_pkg::SR_READY] && !reg_rdata[fcr_pkg::BIT_READY];
    endproperty
    a_ready: assert property (p_ready) else $error("Ready high while busy");
    property p_ready_busy;
        second_hit && !protect_hit && !nmi_or_wdt && !flash_stop_active |=> busy && start_r;
    endproperty
    a_ready_busy: assert property (p_ready_busy) else $error("Operation did not start");
    property p_protect;
        second_hit && protect_hit |=> !start_r && !busy;
    endproperty
    a_protect: assert property (p_protect) else $error("Protected block started");
    property p_err_hold;
        prog_err_r && !clear_cmd && !nmi_or_wdt |=> prog_err_r;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("Error lost");
    property p_prog_fail;
        busy && op_done && op_fail && req_r.kind == fcr_pkg::FCR_OP_PROGRAM && !nmi_or_wdt
            |=> prog_err_r;
    endproperty
    a_prog_fail: assert property (p_prog_fail) else $error("Program error missed");
    property p_stop_idle;
        stop_r && !rewrite_en_r && !nmi_or_wdt |-> !flash_stop_active && !op_abort;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("Stop acted while disabled");
    property p_after_ram;
        busy && op_done && !mode_r && !nmi_or_wdt && !flash_stop_active |=> status_read_sel;
    endproperty
    a_after_ram: assert property (p_after_ram) else $error("Not in status read");
    property p_nmi;
        nmi_or_wdt |=> !rewrite_en_r && !mode_r && !busy && !prog_err_r;
    endproperty
    a_nmi: assert property (p_nmi) else $error("Interrupt did not reset");

    c_flash_mode_op: cover property (mode_r && start_r ##[1:50] op_done);
    c_protect: cover property (second_hit && protect_hit);
    c_fail: cover property (busy && op_done && op_fail);
    c_stop_abort: cover property (op_abort && flash_stop_active);
endmodule

// [fcr_flash_cpu_rewrite_control_test.sv]
`timescale 1ns/1ps
module fcr_flash_cpu_rewrite_control_test;
    // ****************************************************************
    // Signals and design
    // ****************************************************************
    logic clk, arst_n, reg_wr, reg_rd, cmd_wr, op_done, op_fail, nmi_or_wdt;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, status_byte;
    logic [19:0] cmd_addr, ra;
    logic [15:0] cmd_data, rdat;
    logic op_start, op_abort, status_read_sel, cpu_hold, port_freeze, flash_stop_active;
    fcr_pkg::fcr_op_s op_req;
    int bad_count, compares;

    fcr_flash_cpu_rewrite_control fcr_flash_cpu_rewrite_control_inst (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_wr(cmd_wr),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .op_done(op_done), .op_fail(op_fail),
        .nmi_or_wdt(nmi_or_wdt), .op_start(op_start), .op_req(op_req),
        .op_abort(op_abort), .status_read_sel(status_read_sel),
        .status_byte(status_byte), .cpu_hold(cpu_hold), .port_freeze(port_freeze),
        .flash_stop_active(flash_stop_active)
    );

    // ****************************************************************
    // Expectations and checks
    // ****************************************************************
    function automatic logic [7:0] rv(input logic rdy, en, ul, st, pe, ee);
        return {ee, pe, 2'h0, st, ul, en, rdy};
    endfunction

    function automatic fcr_pkg::fcr_op_s exp_req(input logic k, input logic [19:0] a,
                                                 input logic [15:0] d);
        return {k, a, d};
    endfunction

    task automatic chk_bit(input logic got, input logic want);
        compares++;
        if (got !== want) begin
            bad_count++;
            $display("unexpected at %0t: flag got %b want %b", $time, got, want);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] want);
        compares++;
        if (got !== want) begin
            bad_count++;
            $display("unexpected at %0t: byte got %h want %h", $time, got, want);
        end
    endtask

    task automatic chk_req(input fcr_pkg::fcr_op_s got, input fcr_pkg::fcr_op_s want);
        compares++;
        if (got !== want) begin
            bad_count++;
            $display("unexpected at %0t: request got %h want %h", $time, got, want);
        end
    endtask

    task automatic wrap_up;
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Bus drivers
    // ****************************************************************
    // One idle cycle after each strobe keeps every driver single-assignment
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic chkr(input logic [3:0] a, input logic [7:0] want);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk_byte(reg_rdata, want);
    endtask

    task automatic cmd(input logic [19:0] a, input logic [15:0] d);
        @(posedge clk);
        cmd_addr <= a;
        cmd_data <= d;
        cmd_wr <= 1'b1;
        @(posedge clk);
        cmd_wr <= 1'b0;
    endtask

    task automatic done(input logic f);
        @(posedge clk);
        op_done <= 1'b1;
        op_fail <= f;
        @(posedge clk);
        op_done <= 1'b0;
        op_fail <= 1'b0;
        #1;
    endtask

    task automatic prog(input logic [19:0] a, input logic [15:0] d);
        cmd(a, 16'h0040);
        cmd(a, d);
        #1;
    endtask

    task automatic erase(input logic [19:0] ba);
        cmd(20'h00100, 16'h0020);
        cmd(ba, 16'h00D0);
        #1;
    endtask

    // ****************************************************************
    // Clock, watchdog, tests
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (6000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    initial begin
        {arst_n, reg_wr, reg_rd, cmd_wr, op_done, op_fail, nmi_or_wdt} = 7'h00;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        cmd_addr = 20'h00000;
        cmd_data = 16'h0000;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        ra = 20'($urandom(58));
        chkr(4'h0, rv(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        chkr(4'hF, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h1, 8'h02);
        chkr(4'h1, 8'h00);
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h02);
        chkr(4'h0, rv(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        wr(4'h1, 8'h02);
        chkr(4'h1, 8'h00);
        // Random word programs below the protected blocks
        repeat (4) begin
            ra = 20'($urandom) & 20'h7FFFE;
            rdat = 16'($urandom);
            prog(ra, rdat);
            chk_bit(op_start, 1'b1);
            chk_req(op_req, exp_req(1'b0, ra, rdat));
            chk_bit(cpu_hold, 1'b0);
            chkr(4'h0, rv(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
            done(1'b0);
            chk_bit(status_read_sel, 1'b1);
            chkr(4'h0, rv(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        end
        cmd(20'h00200, 16'h0040);
        cmd(20'h00202, 16'h1234);
        #1;
        chk_bit(op_start, 1'b0);
        prog(20'h00300, 16'hA5A5);
        done(1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk_byte(status_byte, 8'h90);
        chkr(4'h0, rv(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0));
        erase(20'h1FFFE);
        chk_req(op_req, exp_req(1'b1, 20'h1FFFE, 16'h00D0));
        done(1'b1);
        chkr(4'h0, rv(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
        cmd(20'h00100, 16'h00FF);
        chkr(4'h0, rv(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
        cmd(20'h00100, 16'h0050);
        chkr(4'h0, rv(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        erase(20'hFFFFE);
        chk_bit(op_start, 1'b0);
        prog(20'hF1000, 16'h1234);
        chk_bit(op_start, 1'b0);
        // Unlock needs its own 0 write just before the 1
        wr(4'h0, 8'h02);
        wr(4'h0, 8'h06);
        erase(20'hFFFFE);
        chk_bit(op_start, 1'b1);
        done(1'b0);
        // Flash-executed mode
        wr(4'h1, 8'h00);
        wr(4'h1, 8'h02);
        chkr(4'h1, 8'h02);
        cmd(20'h00100, 16'h00FF);
        cmd(20'h00100, 16'h0070);
        #1;
        chk_bit(status_read_sel, 1'b0);
        erase(20'h3FFFE);
        chk_bit(cpu_hold, 1'b1);
        chk_bit(port_freeze, 1'b1);
        done(1'b1);
        chk_bit(cpu_hold, 1'b0);
        chk_bit(status_read_sel, 1'b0);
        chkr(4'h0, rv(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
        wr(4'h0, 8'h04);
        #1;
        chk_bit(status_read_sel, 1'b0);
        chkr(4'h1, 8'h00);
        chkr(4'h0, rv(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1));
        // Interrupt in mid-operation
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h02);
        wr(4'h1, 8'h00);
        wr(4'h1, 8'h02);
        prog(20'h00400, 16'h5A5A);
        @(posedge clk);
        nmi_or_wdt <= 1'b1;
        #1;
        chk_bit(op_abort, 1'b1);
        @(posedge clk);
        nmi_or_wdt <= 1'b0;
        chkr(4'h0, rv(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        chkr(4'h1, 8'h00);
        // Stop bit only bites with rewrite enabled
        wr(4'h0, 8'h08);
        #1;
        chk_bit(flash_stop_active, 1'b0);
        chkr(4'h0, rv(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
        wr(4'h0, 8'h0A);
        #1;
        chk_bit(flash_stop_active, 1'b1);
        prog(20'h00500, 16'h0F0F);
        chk_bit(op_start, 1'b0);
        wr(4'h0, 8'h02);
        prog(20'h00600, 16'hF0F0);
        chk_bit(op_start, 1'b1);
        // No completion comes: stop recovers the stuck operation
        wr(4'h0, 8'h0A);
        #1;
        chk_bit(op_abort, 1'b1);
        chkr(4'h0, rv(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
        wrap_up();
    end
endmodule
